// ===== src/sdram_device.sv
// Purpose: Behavioural SDRAM end: command decode, banks, bursts, masks, CKE modes.
// Assumes: Every pin is sampled on the rising edge of mclk.
// Notes: Mode register keeps all address bits; only burst length, burst type and CAS latency are decoded.
`timescale 1ns/10ps
`default_nettype none
`include "sdram_params.svh"
module sdram_device #(
  parameter int ROWS = `ROWS,
  parameter int COLS = `COLS
) (
  input wire logic mclk,
  input wire logic rst,
  sdram_if.dev pins
);
  import sdram_pkg::*;
  localparam int ROW_W = $clog2(ROWS);
  localparam int COL_W = $clog2(COLS);
  localparam int IDX_W = `BA_W + ROW_W + COL_W;

  // The whole array is held here; a testbench may shrink ROWS and COLS.
  logic [`DQ_W-1:0] mem [`NUM_BANKS*ROWS*COLS];

  cmd_e cmd;
  pwr_e pwr_q;
  bur_e bur_q;
  logic run;
  logic [`NUM_BANKS-1:0] open_q;
  logic [ROW_W-1:0] row_q [`NUM_BANKS];
  logic [`ADDR_W-1:0] mode_q;
  logic [`BA_W-1:0] bank_q;
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] cnt_q;
  logic autopre_q;
  logic [COL_W-1:0] mask;
  logic full_page;
  logic new_acc;
  logic acc_on;
  logic acc_rd;
  logic acc_ap;
  logic acc_last;
  logic [`BA_W-1:0] acc_bank;
  logic [COL_W-1:0] acc_start;
  logic [COL_W-1:0] acc_cnt;
  logic [COL_W-1:0] acc_col;
  logic [IDX_W-1:0] acc_idx;
  logic [`DQ_W-1:0] rp_data_q [`MAX_CL];
  logic [`MAX_CL-1:0] rp_val_q;
  logic [`LANES-1:0] dqm1_q;
  logic [`LANES-1:0] dqm2_q;
  logic [2:0] cl;
  logic [1:0] sel;

  // A deselected cycle decodes to no command at all.
  assign cmd = cmd_decode(pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n);

  // The clock counts only with CKE high and outside power-down.
  assign run = pins.cke && (pwr_q == PWR_RUN || pwr_q == PWR_SUSP);

  always_comb begin
    full_page = 1'b0;
    case (mode_q[`MR_BL_POS +: 3])
      3'h0: mask = COL_W'(0);
      3'h1: mask = COL_W'(1);
      3'h2: mask = COL_W'(3);
      3'h3: mask = COL_W'(7);
      3'h7: begin
        mask = COL_W'(COLS - 1);
        full_page = 1'b1;
      end
      default: mask = COL_W'(0);
    endcase
  end

  // A new READ or WRITE takes bank and column from the pins.
  assign new_acc = run && (cmd == CMD_RD || cmd == CMD_WR);
  assign acc_on = new_acc || (run && bur_q != BUR_IDLE && cmd != CMD_BST);
  assign acc_rd = new_acc ? (cmd == CMD_RD) : (bur_q == BUR_RD);
  assign acc_bank = new_acc ? pins.ba : bank_q;
  assign acc_start = new_acc ? pins.addr[COL_W-1:0] : start_q;
  assign acc_cnt = new_acc ? COL_W'(0) : cnt_q;
  assign acc_ap = new_acc ? pins.addr[`AP_BIT] : autopre_q;
  assign acc_last = !full_page && (acc_cnt == mask);

  always_comb begin
    if (mode_q[`MR_BT_POS]) begin
      acc_col = (acc_start & ~mask) | ((acc_start ^ acc_cnt) & mask);
    end else begin
      acc_col = (acc_start & ~mask) | (COL_W'(acc_start + acc_cnt) & mask);
    end
  end

  assign acc_idx = {acc_bank, row_q[acc_bank], acc_col};

  // Clock suspend keeps an unfinished burst or pending read; otherwise a REFRESH
  // picks self refresh, else the bank state picks the power-down flavour. CKE high wakes at once.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_q <= PWR_RUN;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (!pins.cke) begin
            if (bur_q != BUR_IDLE || |rp_val_q) begin
              pwr_q <= PWR_SUSP;
            end else if (cmd == CMD_REF) begin
              pwr_q <= PWR_SREF;
            end else if (|open_q) begin
              pwr_q <= PWR_PDN_ACT;
            end else begin
              pwr_q <= PWR_PDN_PRE;
            end
          end
        end
        PWR_SUSP, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SREF: begin
          if (pins.cke) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  // Each running edge with a burst beat steps the column counter of the burst.
  always_ff @(posedge mclk) begin
    if (rst) begin
      bur_q <= BUR_IDLE;
      cnt_q <= '0;
      bank_q <= '0;
      start_q <= '0;
      autopre_q <= 1'b0;
    end else if (run) begin
      if (acc_on) begin
        bur_q <= acc_last ? BUR_IDLE : (acc_rd ? BUR_RD : BUR_WR);
        cnt_q <= COL_W'(acc_cnt + COL_W'(1));
        bank_q <= acc_bank;
        start_q <= acc_start;
        autopre_q <= acc_ap;
      end else if (cmd == CMD_BST) begin
        bur_q <= BUR_IDLE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      open_q <= '0;
      for (int b = 0; b < `NUM_BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else if (run) begin
      case (cmd)
        CMD_ACT: begin
          open_q[pins.ba] <= 1'b1;
          row_q[pins.ba] <= pins.addr[ROW_W-1:0];
        end
        CMD_PRE: begin
          if (pins.addr[`AP_BIT]) begin
            open_q <= '0;
          end else begin
            open_q[pins.ba] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
      // With auto-precharge, the row closes itself on the last beat of a burst that runs to its length.
      if (acc_on && acc_last && acc_ap) begin
        open_q[acc_bank] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= `MR_RESET;
    end else if (run && cmd == CMD_MRS) begin
      mode_q <= pins.addr;
    end
  end

  // Only unmasked lanes are stored; mask bit i owns byte i.
  always_ff @(posedge mclk) begin
    if (acc_on && !acc_rd) begin
      for (int i = 0; i < `LANES; i++) begin
        if (!pins.dqm[i]) begin
          mem[acc_idx][i*`LANE_W +: `LANE_W] <= pins.dq[i*`LANE_W +: `LANE_W];
        end
      end
    end
  end

  // Read words move through output registers on each running edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rp_val_q <= '0;
      for (int s = 0; s < `MAX_CL; s++) begin
        rp_data_q[s] <= '0;
      end
    end else if (run) begin
      rp_val_q <= {rp_val_q[`MAX_CL-2:0], acc_on && acc_rd};
      rp_data_q[0] <= mem[acc_idx];
      for (int s = 1; s < `MAX_CL; s++) begin
        rp_data_q[s] <= rp_data_q[s-1];
      end
    end
  end

  // Masks keep working while deselected; suspend freezes their delay.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dqm1_q <= '0;
      dqm2_q <= '0;
    end else if (run) begin
      dqm1_q <= pins.dqm;
      dqm2_q <= dqm1_q;
    end
  end

  // Unsupported latencies fall back to the nearest one held.
  assign cl = mode_q[`MR_CL_POS +: 3];
  assign sel = (cl == 3'h0) ? 2'h0 : ((cl > 3'(`MAX_CL)) ? 2'(`MAX_CL - 1) : 2'(cl - 3'h1));

  assign pins.dq_dev = rp_data_q[sel];
  assign pins.dq_dev_oe = {`LANES{rp_val_q[sel]}} & ~dqm2_q;
endmodule
`default_nettype wire

// ===== src/sdram_params.svh
// Purpose: Shared constants of the SDRAM pin interface.
// Assumes: Included by the package and both ends.
// Notes: Definitions only.
`ifndef SDRAM_PARAMS_SVH
`define SDRAM_PARAMS_SVH
`define NUM_BANKS 4
`define BA_W 2
`define ROWS 4096
`define COLS 256
`define ADDR_W 12
`define COL_W 8
`define DQ_W 32
`define LANES 4
`define LANE_W 8
`define AP_BIT 10
`define MAX_CL 3
`define DQM_RD_LAT 2
`define MR_BL_POS 0
`define MR_BT_POS 3
`define MR_CL_POS 4
`define MR_RESET 12'h020
`define CKE_RESET 1'b1
`endif

// ===== src/sdram_pkg.sv
// Purpose: Types shared by both ends of the SDRAM pin interface.
// Assumes: Command code is {cs_n, ras_n, cas_n, we_n}.
// Notes: Deselect covers every code with cs_n high.
`include "sdram_params.svh"
package sdram_pkg;
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_BST = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_e;
  typedef enum logic [4:0] {
    PWR_RUN = 5'b00001,
    PWR_SUSP = 5'b00010,
    PWR_PDN_PRE = 5'b00100,
    PWR_PDN_ACT = 5'b01000,
    PWR_SREF = 5'b10000
  } pwr_e;
  typedef enum logic [2:0] {
    BUR_IDLE = 3'b001,
    BUR_RD = 3'b010,
    BUR_WR = 3'b100
  } bur_e;
  function automatic cmd_e cmd_decode(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_e c;
    c = CMD_DESEL;
    if (!cs_n) begin
      c = cmd_e'({1'b0, ras_n, cas_n, we_n});
    end
    return c;
  endfunction
endpackage

// ===== src/sdram_if.sv
// Purpose: Pin bundle between the memory controller and the SDRAM.
// Assumes: Each end drives its own copy of the data bus; the device with lane enables, the controller with one enable.
// Notes: The resolved bus reads zero on lanes nobody drives.
`timescale 1ns/10ps
`default_nettype none
`include "sdram_params.svh"
interface sdram_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`BA_W-1:0] ba;
  logic [`ADDR_W-1:0] addr;
  logic [`LANES-1:0] dqm;
  logic [`DQ_W-1:0] dq_ctrl;
  logic dq_ctrl_oe;
  logic [`DQ_W-1:0] dq_dev;
  logic [`LANES-1:0] dq_dev_oe;
  logic [`DQ_W-1:0] dq;
  always_comb begin
    dq = '0;
    for (int i = 0; i < `LANES; i++) begin
      if (dq_dev_oe[i]) begin
        dq[i*`LANE_W +: `LANE_W] = dq_dev[i*`LANE_W +: `LANE_W];
      end else if (dq_ctrl_oe) begin
        dq[i*`LANE_W +: `LANE_W] = dq_ctrl[i*`LANE_W +: `LANE_W];
      end
    end
  end
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
               output dq_dev, dq_dev_oe);
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctrl,
                dq_ctrl_oe, input dq, dq_dev_oe);
endinterface
`default_nettype wire

// ===== src/sdram_ctrl.sv
// Purpose: Controller end that drives the SDRAM pins from user requests.
// Assumes: The user keeps command timing legal.
// Notes: Pins change one cycle after the request is offered.
`timescale 1ns/10ps
`default_nettype none
`include "sdram_params.svh"
module sdram_ctrl (
  input wire logic mclk,
  input wire logic rst,
  sdram_if.ctrl pins,
  input wire logic req_valid,
  input wire sdram_pkg::cmd_e req_cmd,
  input wire logic [`BA_W-1:0] req_bank,
  input wire logic [`ADDR_W-1:0] req_row,
  input wire logic [`COL_W-1:0] req_col,
  input wire logic req_flag,
  input wire logic [`ADDR_W-1:0] req_opcode,
  input wire logic [`LANES-1:0] req_dqm,
  input wire logic [`DQ_W-1:0] req_wdata,
  input wire logic req_wdrive,
  input wire logic cke_req,
  output logic [`DQ_W-1:0] rdata,
  output logic [`LANES-1:0] rdata_lanes,
  output logic rdata_valid
);
  import sdram_pkg::*;
  logic [3:0] code_q;
  logic [`ADDR_W-1:0] addr_d;
  logic [`ADDR_W-1:0] addr_q;
  logic [`BA_W-1:0] ba_q;
  logic [`LANES-1:0] dqm_q;
  logic [`DQ_W-1:0] wdata_q;
  logic wdrive_q;
  logic cke_q;

  // Address bits carry row, column with bit 10, or the opcode.
  always_comb begin
    addr_d = '0;
    case (req_cmd)
      CMD_ACT: addr_d = req_row;
      CMD_RD, CMD_WR: begin
        addr_d[`COL_W-1:0] = req_col;
        addr_d[`AP_BIT] = req_flag;
      end
      CMD_PRE: addr_d[`AP_BIT] = req_flag;
      CMD_MRS: addr_d = req_opcode;
      default: addr_d = '0;
    endcase
  end

  // All four strobes leave one register together, as does CKE.
  always_ff @(posedge mclk) begin
    if (rst) begin
      code_q <= 4'hF;
      cke_q <= `CKE_RESET;
      addr_q <= '0;
      ba_q <= '0;
    end else begin
      code_q <= req_valid ? 4'(req_cmd) : 4'(CMD_NOP);
      cke_q <= cke_req;
      addr_q <= req_valid ? addr_d : '0;
      ba_q <= req_bank;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dqm_q <= '0;
      wdata_q <= '0;
      wdrive_q <= 1'b0;
    end else begin
      dqm_q <= req_dqm;
      wdata_q <= req_wdata;
      wdrive_q <= req_wdrive;
    end
  end

  // Read data is taken whenever the memory drives any lane.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
      rdata_lanes <= '0;
      rdata_valid <= 1'b0;
    end else begin
      rdata <= pins.dq;
      rdata_lanes <= pins.dq_dev_oe;
      rdata_valid <= |pins.dq_dev_oe;
    end
  end

  assign pins.cs_n = code_q[3];
  assign pins.ras_n = code_q[2];
  assign pins.cas_n = code_q[1];
  assign pins.we_n = code_q[0];
  assign pins.cke = cke_q;
  assign pins.addr = addr_q;
  assign pins.ba = ba_q;
  assign pins.dqm = dqm_q;
  assign pins.dq_ctrl = wdata_q;
  assign pins.dq_ctrl_oe = wdrive_q;
endmodule
`default_nettype wire

// ===== testbench/sdram_pin_props.sv
// Purpose: Pin-level checks across the SDRAM interface.
// Assumes: Mode stays at CAS latency 2 and burst length 1.
// Notes: Sees only interface signals; no clock suspend in mid-burst.
`timescale 1ns/10ps
`default_nettype none
`include "sdram_params.svh"
module sdram_pin_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`LANES-1:0] dqm,
  input wire logic dq_ctrl_oe,
  input wire logic [`LANES-1:0] dq_dev_oe
);
  logic rd;
  logic wr;
  assign rd = cke && !cs_n && ras_n && !cas_n && we_n;
  assign wr = cke && !cs_n && ras_n && !cas_n && !we_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A read taken on a wake edge is ignored, so a live read needs cke high one edge earlier.
  sequence rd_s;
    rd && $past(cke);
  endsequence
  sequence quiet3_s;
    (!rd) [*3];
  endsequence
  rd_mask_lat_a: assert property (rd_s |-> ##2 dq_dev_oe == ~$past(dqm, 2))
    else $error("read lane drive does not follow mask");
  idle_quiet_a: assert property (quiet3_s |-> dq_dev_oe == '0)
    else $error("device drives without a read");
  rd_once_a: assert property (rd_s ##1 !rd |=> ##1 dq_dev_oe == '0)
    else $error("read beat lasts too long");
  cke_freeze_a: assert property (!cke |=> $stable(dq_dev_oe))
    else $error("outputs moved with clock enable low");
  wake_ign_a: assert property (!cke ##1 rd |-> ##2 dq_dev_oe == '0)
    else $error("command taken on wake edge");
  rd_cause_a: assert property ((dq_dev_oe != '0 && $past(dq_dev_oe) == '0)
    |-> $past(rd, 2) && $past(cke, 3)) else $error("drive without a decoded read");
  wr_quiet_a: assert property ((!rd) [*2] ##1 wr |-> dq_dev_oe == '0)
    else $error("device drives during write");
  rst_idle_a: assert property (disable iff (1'b0)
    rst |=> cs_n && cke && !dq_ctrl_oe && dq_dev_oe == '0) else $error("reset state wrong");
endmodule
`default_nettype wire

// ===== testbench/test_sdram_pin_command_interface.sv
// Purpose: Drives the controller end against the device end and checks read data.
// Assumes: Mode CL2, burst length 1; banks shrunk to 16 rows by 16 columns.
// Notes: Every rd_chk read is chased by a deselect request with a CL3 opcode, which the controller puts on the pins as address zero.
`timescale 1ns/10ps
`default_nettype none
`include "sdram_params.svh"
module test_sdram_pin_command_interface;
  import sdram_pkg::*;
  logic mclk;
  logic rst;
  logic req_valid;
  cmd_e req_cmd;
  logic [`BA_W-1:0] req_bank;
  logic [`ADDR_W-1:0] req_a;
  logic [`LANES-1:0] req_dqm;
  logic [`DQ_W-1:0] req_wdata;
  logic req_wdrive;
  logic cke_req;
  logic [`DQ_W-1:0] rdata;
  logic [`LANES-1:0] rdata_lanes;
  logic rdata_valid;
  int error_cnt;
  int checks_done;
  sdram_if pins();
  sdram_ctrl i_sdram_ctrl (.mclk(mclk), .rst(rst), .pins(pins), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_row(req_a), .req_col(req_a[7:0]),
    .req_flag(req_a[10]), .req_opcode(req_a), .req_dqm(req_dqm), .req_wdata(req_wdata),
    .req_wdrive(req_wdrive), .cke_req(cke_req), .rdata(rdata), .rdata_lanes(rdata_lanes),
    .rdata_valid(rdata_valid));
  sdram_device #(.ROWS(16), .COLS(16)) i_sdram_device (.mclk(mclk), .rst(rst), .pins(pins));
  sdram_pin_props i_sdram_pin_props (.mclk(mclk), .rst(rst), .cke(pins.cke), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .dqm(pins.dqm),
    .dq_ctrl_oe(pins.dq_ctrl_oe), .dq_dev_oe(pins.dq_dev_oe));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The request is left up, so back-to-back calls assign each input once per time step.
  task automatic op(input cmd_e c, input logic [1:0] b, input logic [11:0] a,
                    input logic [3:0] m, input logic [31:0] d);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_a = a;
    req_dqm = m;
    req_wdata = d;
    req_wdrive = (c == CMD_WR);
    @(posedge mclk);
    #1;
  endtask
  task automatic idle(input int n);
    req_valid = 1'b0;
    req_wdrive = 1'b0;
    req_dqm = 4'h0;
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic rd_chk(input logic [1:0] b, input logic [3:0] m, input logic [31:0] exp);
    int n;
    op(CMD_RD, b, 12'h005, m, 32'h0);
    op(CMD_DESEL, b, 12'h030, 4'h0, 32'h0);
    n = 0;
    while (rdata_valid !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // Two edges after the deselect: a wrongly taken latency opcode would show up here.
    chk("rd_latency", 32'h2, n);
    chk("rdata_valid", 32'h1, {31'h0, rdata_valid});
    chk("rdata", exp, rdata);
    chk("rdata_lanes", {28'h0, ~m}, {28'h0, rdata_lanes});
    idle(3);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // The sequence needs about 90 cycles; 1000 cycles leaves ample margin.
  initial begin
    #5000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_bank = 2'h0;
    req_a = 12'h000;
    req_dqm = 4'h0;
    req_wdata = 32'h0;
    req_wdrive = 1'b0;
    cke_req = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    op(CMD_MRS, 2'h0, 12'h020, 4'h0, 32'h0);
    op(CMD_ACT, 2'h1, 12'h003, 4'h0, 32'h0);
    op(CMD_ACT, 2'h2, 12'h003, 4'h0, 32'h0);
    op(CMD_WR, 2'h1, 12'h005, 4'h0, 32'h11223344);
    op(CMD_WR, 2'h1, 12'h005, 4'h2, 32'hAABBCCDD);
    op(CMD_WR, 2'h2, 12'h005, 4'h0, 32'h55667788);
    idle(3);
    rd_chk(2'h1, 4'h0, 32'hAABB33DD);
    for (int i = 0; i < 4; i++) begin
      rd_chk(2'h1, 4'h1 << i, 32'hAABB33DD & ~(32'hFF << (8 * i)));
    end
    rd_chk(2'h2, 4'h0, 32'h55667788);
    cke_req = 1'b0;
    op(CMD_WR, 2'h2, 12'h005, 4'h0, 32'hDEADBEEF);
    cke_req = 1'b1;
    op(CMD_RD, 2'h2, 12'h005, 4'h0, 32'h0);
    chk("pwr_state", PWR_PDN_ACT, i_sdram_device.pwr_q);
    idle(3);
    rd_chk(2'h2, 4'h0, 32'h55667788);
    op(CMD_PRE, 2'h1, 12'h000, 4'h0, 32'h0);
    idle(1);
    chk("open_banks", 32'h4, {28'h0, i_sdram_device.open_q});
    op(CMD_RD, 2'h2, 12'h405, 4'h0, 32'h0);
    idle(3);
    chk("open_banks", 32'h0, {28'h0, i_sdram_device.open_q});
    op(CMD_ACT, 2'h0, 12'h001, 4'h0, 32'h0);
    op(CMD_ACT, 2'h3, 12'h001, 4'h0, 32'h0);
    op(CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
    chk("open_banks", 32'h9, {28'h0, i_sdram_device.open_q});
    idle(1);
    chk("open_banks", 32'h0, {28'h0, i_sdram_device.open_q});
    cke_req = 1'b0;
    idle(2);
    chk("pwr_state", PWR_PDN_PRE, i_sdram_device.pwr_q);
    cke_req = 1'b1;
    idle(2);
    cke_req = 1'b0;
    op(CMD_REF, 2'h0, 12'h000, 4'h0, 32'h0);
    idle(1);
    chk("pwr_state", PWR_SREF, i_sdram_device.pwr_q);
    cke_req = 1'b1;
    idle(3);
    rd_chk(2'h1, 4'h0, 32'hAABB33DD);
    print_verdict();
  end
endmodule
`default_nettype wire
